/* include/bitcall_pkg.sv */
// Constants for the bit-operation and subroutine-call execution block
`default_nettype none
package bitcall_pkg;
    // ----------------------------------------------------------------
    // Instruction word layout
    // ----------------------------------------------------------------
    localparam int INSTR_W    = 14;
    localparam int OPC_HI     = 13;                 // Top of major opcode
    localparam int OPC_LO     = 12;
    localparam int SUB_HI     = 11;                 // Bit-op sub opcode
    localparam int SUB_LO     = 10;
    localparam int BIT_HI     = 9;                  // Bit position field
    localparam int BIT_LO     = 7;
    localparam int REG_HI     = 6;                  // Register address
    localparam int REG_LO     = 0;
    localparam int CALL_SEL   = 11;                 // 0 selects call
    localparam int IMM_HI     = 10;                 // Call immediate
    localparam int IMM_LO     = 0;

    // ----------------------------------------------------------------
    // Opcode codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MAJ_BITOP = 2'h1;
    localparam logic [1:0] MAJ_CTRL  = 2'h2;
    localparam logic [1:0] SUB_CLR   = 2'h0;
    localparam logic [1:0] SUB_SET   = 2'h1;
    localparam logic [1:0] SUB_TSTZ  = 2'h2;
    localparam logic [1:0] SUB_TSTO  = 2'h3;

    // ----------------------------------------------------------------
    // Page latch and program counter layout
    // ----------------------------------------------------------------
    localparam int PAGE_HI    = 4;
    localparam int PAGE_LO    = 3;
    localparam int PC_W       = 13;
    localparam int LATCH_W    = 8;
    localparam int DATA_W     = 8;

    // ----------------------------------------------------------------
    // Reset values and cycle figures
    // ----------------------------------------------------------------
    localparam logic [7:0]  DATA_RST  = 8'h00;
    localparam logic [12:0] PC_RST    = 13'h0000;
    localparam logic [6:0]  ADDR_RST  = 7'h00;
    localparam int          CALL_CYC  = 2;          // Cycles of a call
    localparam int          SKIP_CYC  = 2;          // Cycles of a skip

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_NOP = 2'b10
    } exec_state_t;
endpackage
`default_nettype wire

/* core/bit_ops_and_call_exec.sv */
// Execute stage for bit clear/set, bit test-and-skip and subroutine call
`default_nettype none
module bit_ops_and_call_exec #(
    parameter int ADDR_W = 7,
    parameter int PC_W   = bitcall_pkg::PC_W
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    input  wire logic                  i_instr_valid,
    input  wire logic [13:0]           i_instr,
    input  wire logic [7:0]            i_operand,
    input  wire logic [PC_W-1:0]       i_pc,
    input  wire logic [7:0]            i_page_latch,
    output logic                       o_reg_we,
    output logic [ADDR_W-1:0]          o_reg_addr,
    output logic [7:0]                 o_reg_wdata,
    output logic                       o_flush,
    output logic                       o_nop_cycle,
    output logic                       o_stack_push,
    output logic [PC_W-1:0]            o_stack_top_entry,
    output logic                       o_pc_load,
    output logic [PC_W-1:0]            o_pc_value,
    output logic                       o_flags_we
);
    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (ADDR_W != bitcall_pkg::REG_HI - bitcall_pkg::REG_LO + 1) begin : g_aw
        $error("ADDR_W must match the register field");
    end
    if (PC_W != bitcall_pkg::PC_W) begin : g_pw
        $error("PC_W must be thirteen");
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    // Mask with a single bit set at the chosen position
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction

    bitcall_pkg::exec_state_t state;

    logic [1:0]  major;
    logic [1:0]  sub;
    logic [2:0]  bit_pos;
    logic        accept;
    logic        bit_op;
    logic        call_op;
    logic        sel_bit;
    logic        next_skip;

    assign major   = i_instr[bitcall_pkg::OPC_HI:bitcall_pkg::OPC_LO];
    assign sub     = i_instr[bitcall_pkg::SUB_HI:bitcall_pkg::SUB_LO];
    assign bit_pos = i_instr[bitcall_pkg::BIT_HI:bitcall_pkg::BIT_LO];
    // A fetched word is ignored while the flushed slot executes a NOP
    assign accept  = i_instr_valid && (state == bitcall_pkg::ST_RUN);
    assign bit_op  = accept && (major == bitcall_pkg::MAJ_BITOP);
    assign call_op = accept && (major == bitcall_pkg::MAJ_CTRL)
                     && !i_instr[bitcall_pkg::CALL_SEL];
    assign sel_bit = |(i_operand & bit_mask(bit_pos));
    // Skip decision for either test opcode
    assign next_skip = bit_op
        && (((sub == bitcall_pkg::SUB_TSTZ) && !sel_bit)
         || ((sub == bitcall_pkg::SUB_TSTO) && sel_bit));

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Skip and call both stretch to a second, NOP cycle
    // A word offered in that slot is lost, so fetch must hold it back
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= bitcall_pkg::ST_RUN;
        end else begin
            case (state)
                bitcall_pkg::ST_RUN: begin
                    if (next_skip || call_op) begin
                        state <= bitcall_pkg::ST_NOP;
                    end
                end
                bitcall_pkg::ST_NOP: begin
                    state <= bitcall_pkg::ST_RUN;
                end
                default: begin
                    state <= bitcall_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Marks the discarded slot; registered for a clean output
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flush     <= 1'b0;
            o_nop_cycle <= 1'b0;
        end else begin
            o_flush     <= next_skip || call_op;
            o_nop_cycle <= (state == bitcall_pkg::ST_RUN)
                           && (next_skip || call_op);
        end
    end

    // ----------------------------------------------------------------
    // Register file write-back
    // ----------------------------------------------------------------
    // Read-modify-write of the whole byte; tests write nothing
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_we    <= 1'b0;
            o_reg_addr  <= bitcall_pkg::ADDR_RST;
            o_reg_wdata <= bitcall_pkg::DATA_RST;
        end else begin
            o_reg_we   <= bit_op && (sub == bitcall_pkg::SUB_CLR
                                  || sub == bitcall_pkg::SUB_SET);
            o_reg_addr <= i_instr[bitcall_pkg::REG_HI:bitcall_pkg::REG_LO];
            if (sub == bitcall_pkg::SUB_CLR) begin
                o_reg_wdata <= i_operand & ~bit_mask(bit_pos);
            end else begin
                o_reg_wdata <= i_operand | bit_mask(bit_pos);
            end
        end
    end

    // None of these opcodes touches the status flags
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_flags_we <= 1'b0;
        end else begin
            o_flags_we <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Call: stack push and program counter load
    // ----------------------------------------------------------------
    // Push and load land together; the stack gets the return address, i_pc plus one
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stack_push      <= 1'b0;
            o_stack_top_entry <= bitcall_pkg::PC_RST;
            o_pc_load         <= 1'b0;
            o_pc_value        <= bitcall_pkg::PC_RST;
        end else begin
            o_stack_push <= call_op;
            o_pc_load    <= call_op;
            if (call_op) begin
                o_stack_top_entry <= i_pc + 13'h0001;
                o_pc_value <= {
                    i_page_latch[bitcall_pkg::PAGE_HI:bitcall_pkg::PAGE_LO],
                    i_instr[bitcall_pkg::IMM_HI:bitcall_pkg::IMM_LO]
                };
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Each check looks one or two edges past the edge that took the word
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    AST_CLR_WRITE: assert property (
        bit_op && sub == bitcall_pkg::SUB_CLR |=> o_reg_we
        && o_reg_wdata == ($past(i_operand) & ~bit_mask($past(bit_pos))))
        else $error("bit clear wrote wrong value");
    AST_SET_WRITE: assert property (
        bit_op && sub == bitcall_pkg::SUB_SET |=> o_reg_we
        && o_reg_wdata[$past(bit_pos)] && o_reg_addr == $past(i_instr[6:0]))
        else $error("bit set did not set bit");
    AST_TSTZ_SKIP: assert property (
        bit_op && sub == bitcall_pkg::SUB_TSTZ |=> o_flush == !$past(sel_bit)
        && !o_reg_we)
        else $error("skip-if-zero wrong");
    AST_TSTO_SKIP: assert property (
        bit_op && sub == bitcall_pkg::SUB_TSTO |=> o_flush == $past(sel_bit))
        else $error("skip-if-one wrong");
    AST_SKIP_TWO: assert property (
        next_skip |=> state == bitcall_pkg::ST_NOP && o_nop_cycle
        ##1 state == bitcall_pkg::ST_RUN)
        else $error("skip not two cycles");
    AST_PUSH_RET: assert property (
        call_op |=> o_stack_push && o_stack_top_entry == $past(i_pc) + 13'h1)
        else $error("call pushed wrong return");
    AST_PC_LOW: assert property (
        call_op |=> o_pc_load && o_pc_value[10:0] == $past(i_instr[10:0]))
        else $error("call low bits wrong");
    AST_PC_HIGH: assert property (
        call_op |=> o_pc_value[12:11] == $past(i_page_latch[4:3]))
        else $error("call page bits wrong");
    AST_CALL_TWO: assert property (
        call_op |=> !accept ##1 state == bitcall_pkg::ST_RUN && !o_flags_we)
        else $error("call not two cycles");

    // Nothing lands from a word offered in the forced NOP slot
    AST_NOP_REFUSED: assert property (
        state == bitcall_pkg::ST_NOP |=> !o_reg_we && !o_stack_push
        && !o_pc_load && !o_flush)
        else $error("word taken in the NOP slot");

    // A control word with the select bit high leaves the stack alone
    AST_NOT_CALL: assert property (
        accept && major == bitcall_pkg::MAJ_CTRL
        && i_instr[bitcall_pkg::CALL_SEL] |=> !o_stack_push && !o_pc_load)
        else $error("non-call word pushed the stack");

    // Writes come only from a bit clear or bit set one edge earlier
    AST_WE_SOURCE: assert property (
        o_reg_we |-> $past(bit_op) && ($past(sub) == bitcall_pkg::SUB_CLR
        || $past(sub) == bitcall_pkg::SUB_SET))
        else $error("register write without bit clear or set");

    // Main scenarios reached
    COV_CLR:  cover property (bit_op && sub == bitcall_pkg::SUB_CLR);
    COV_SKIP: cover property (next_skip ##2 next_skip);
    COV_NOSK: cover property (bit_op && sub == bitcall_pkg::SUB_TSTO
                              && !sel_bit);
    COV_CALL: cover property (call_op ##2 call_op);
    COV_REFUSED: cover property (state == bitcall_pkg::ST_NOP
                                 && i_instr_valid);
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the bit-operation and call execute stage
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_instr_valid = 1'b0;
    logic [13:0] i_instr = 14'h0000;
    logic [7:0]  i_operand = 8'h00;
    logic [12:0] i_pc = 13'h0000;
    logic [7:0]  i_page_latch = 8'h00;
    logic        o_reg_we, o_flush, o_nop_cycle, o_stack_push;
    logic        o_pc_load, o_flags_we;
    logic [6:0]  o_reg_addr;
    logic [7:0]  o_reg_wdata;
    logic [12:0] o_stack_top_entry, o_pc_value;
    int          n_fail = 0;
    int          check_count = 0;

    bit_ops_and_call_exec u_bit_ops_and_call_exec (.i_clk(i_clk),
        .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_operand(i_operand), .i_pc(i_pc), .i_page_latch(i_page_latch),
        .o_reg_we(o_reg_we), .o_reg_addr(o_reg_addr),
        .o_reg_wdata(o_reg_wdata), .o_flush(o_flush),
        .o_nop_cycle(o_nop_cycle), .o_stack_push(o_stack_push),
        .o_stack_top_entry(o_stack_top_entry), .o_pc_load(o_pc_load),
        .o_pc_value(o_pc_value), .o_flags_we(o_flags_we));

    // 50 MHz instruction clock
    always #10 i_clk = ~i_clk;

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic compare(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Present one word at the next edge; valid stays up so words can
    // follow back to back without lowering and raising it in one step
    task automatic issue(input logic [13:0] w, input logic [7:0] opnd);
        i_instr = w;
        i_operand = opnd;
        i_instr_valid = 1'b1;
        @(posedge i_clk);
        #1;
    endtask

    // Drop valid and let one edge pass with nothing offered
    task automatic idle();
        i_instr_valid = 1'b0;
        @(posedge i_clk);
        #1;
    endtask

    // Strobes of a one-cycle instruction with a register write
    task automatic expect_write(input logic [6:0] a, input logic [7:0] d);
        compare(o_reg_we, 1'b1);
        compare(o_reg_addr, a);
        compare(o_reg_wdata, d);
        compare({o_flush, o_nop_cycle, o_stack_push, o_pc_load}, 4'h0);
        compare(o_flags_we, 1'b0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Clear and set every bit position, back to back
    task automatic t_clear_set();
        for (int b = 0; b < 8; b++) begin
            issue({4'h4, b[2:0], 7'h7F - 7'(b)}, 8'hFF);
            expect_write(7'h7F - 7'(b), 8'hFF & ~(8'h01 << b));
            issue({4'h5, b[2:0], 7'(b)}, 8'h00);
            expect_write(7'(b), 8'h01 << b);
        end
        idle();
        compare(o_reg_we, 1'b0);
    endtask

    // Skip when tested bit is zero; next word in the slot is dropped
    task automatic t_skip_zero();
        issue({4'h6, 3'h3, 7'h15}, 8'hF7);
        compare({o_flush, o_nop_cycle, o_reg_we}, 3'h6);
        compare(o_flags_we, 1'b0);
        issue({4'h5, 3'h0, 7'h22}, 8'h00);
        compare({o_flush, o_nop_cycle, o_reg_we}, 3'h0);
        issue({4'h4, 3'h1, 7'h23}, 8'h03);
        expect_write(7'h23, 8'h01);
    endtask

    // Skip-if-one not taken, then taken; tests themselves never write
    task automatic t_skip_one();
        issue({4'h7, 3'h0, 7'h30}, 8'hFE);
        compare({o_flush, o_nop_cycle, o_reg_we}, 3'h0);
        issue({4'h7, 3'h7, 7'h31}, 8'h80);
        compare({o_flush, o_nop_cycle, o_reg_we}, 3'h6);
        compare(o_flags_we, 1'b0);
        idle();
        compare({o_flush, o_nop_cycle}, 2'h0);
        issue({4'h6, 3'h5, 7'h32}, 8'h20);
        compare({o_flush, o_nop_cycle}, 2'h0);
    endtask

    // Calls at the immediate extremes and with page bits 11 and 00
    task automatic t_call();
        i_pc = 13'h0ABC;
        i_page_latch = 8'h18;
        issue({3'h4, 11'h7FF}, 8'h00);
        compare({o_stack_push, o_pc_load, o_flush}, 3'h7);
        compare(o_stack_top_entry, 13'h0ABD);
        compare(o_pc_value, {i_page_latch[4:3], 11'h7FF});
        compare({o_nop_cycle, o_flags_we, o_reg_we}, 3'h4);
        i_pc = 13'h1234;
        i_page_latch = 8'hE7;
        issue({3'h4, 11'h000}, 8'h00);
        compare({o_stack_push, o_pc_load}, 2'h0);
        compare(o_pc_value, 13'h1FFF);
        issue({3'h4, 11'h000}, 8'h00);
        compare(o_stack_top_entry, 13'h1235);
        compare(o_pc_value, 13'h0000);
        compare({o_stack_push, o_pc_load, o_flags_we}, 3'h6);
        idle();
        compare({o_stack_push, o_pc_load, o_nop_cycle}, 3'h0);
        // Control word with the select bit high is not a call
        issue({3'h5, 11'h123}, 8'h00);
        compare({o_stack_push, o_pc_load, o_flush}, 3'h0);
        compare(o_pc_value, 13'h0000);
    endtask

    // ------------------------------------------------------------
    // Verdict and sequencing
    // ------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is well under a hundred cycles; this cuts off a hang
    initial begin
        repeat (2000) @(posedge i_clk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        compare({o_reg_we, o_stack_push, o_pc_load, o_flush}, 4'h0);
        compare(o_pc_value, 13'h0000);
        t_clear_set();
        t_skip_zero();
        t_skip_one();
        t_call();
        conclude();
    end
endmodule
`default_nettype wire
